// [core/sbmc_top.sv]
// bus mode control: apb registers, link clock sampling, frame sequencer
// assumes apb3 master on pclk; xfer_clk, scl_i, sda_i are asynchronous pins
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "sbmc_regs.svh"
module sbmc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xfer_clk,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             bit_order_select,
  output logic             wait_enable
);

  typedef struct packed {
    logic [2:0]  xs;
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        bit_order_select;
    logic        wait_enable;
    logic        two_wire;
    logic        master;
    logic [7:0]  tx;
    logic        start;
    logic        load;
    logic [2:0]  load_code;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sbmc_top_st_t;

  sbmc_top_st_t st;
  sbmc_top_st_t next_st;
  sbmc_frame_if fi ();

  logic        acc;
  logic        wr_now;
  logic [31:0] rd;
  logic        hit;

  always_comb begin
    next_st = st;
    // two flops per pin; xs[2] is history for edge finding
    next_st.xs    = {st.xs[1:0], xfer_clk};
    next_st.scl_s = {st.scl_s[0], scl_i};
    next_st.sda_s = {st.sda_s[0], sda_i};
    next_st.start = 1'b0;
    next_st.load  = 1'b0;
    acc    = psel & penable & ~st.pready;
    wr_now = psel & penable & st.pready & pwrite;
    hit    = 1'b1;
    rd     = 32'h0000_0000;
    unique case (paddr)
      `SBMC_OFF_MODE: begin
        rd[7:0] = {st.bit_order_select, st.wait_enable, 6'h00} | `SBMC_MODE_RSVD
                  | `SBMC_MODE_GUARD_RD | {5'h00, fi.field};
      end
      `SBMC_OFF_LINK: begin
        rd[1:0] = {st.master, st.two_wire};
      end
      `SBMC_OFF_TXDATA: begin
        rd[7:0] = st.tx;
      end
      `SBMC_OFF_STATUS: begin
        rd[`SBMC_STAT_BUSY] = fi.busy;
        rd[`SBMC_STAT_SCL]  = st.scl_s[1];
        rd[`SBMC_STAT_SDA]  = st.sda_s[1];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // one wait state: ready answers the cycle after the access phase opens
    next_st.pready  = acc;
    next_st.pslverr = acc & ~hit;
    if (acc) begin
      next_st.prdata = rd;
    end
    if (wr_now && paddr == `SBMC_OFF_MODE) begin
      next_st.bit_order_select = pwdata[`SBMC_MODE_ORDER_BIT];
      next_st.wait_enable      = pwdata[`SBMC_MODE_WAIT_BIT];
      // guard and count come from this same write, never a stored guard
      if (!pwdata[`SBMC_MODE_GUARD_BIT]) begin
        next_st.load      = 1'b1;
        next_st.load_code = pwdata[2:0];
      end
      // guard set: count bits fall away
    end
    if (wr_now && paddr == `SBMC_OFF_LINK) begin
      next_st.two_wire = pwdata[`SBMC_LINK_TWO_WIRE];
      next_st.master   = pwdata[`SBMC_LINK_MASTER];
      next_st.start    = pwdata[`SBMC_LINK_START] & ~fi.busy;
    end
    if (wr_now && paddr == `SBMC_OFF_TXDATA) begin
      next_st.tx = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{xs: 3'h0, scl_s: 2'h3, sda_s: 2'h3,
              bit_order_select: `SBMC_ORDER_RESET,
              wait_enable: `SBMC_WAIT_RESET, two_wire: `SBMC_TWO_WIRE_RESET,
              master: `SBMC_MASTER_RESET, tx: 8'h00, start: 1'b0, load: 1'b0,
              load_code: 3'h0,
              pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign fi.two_wire  = st.two_wire;
  assign fi.master    = st.master;
  assign fi.msb_first = ~st.bit_order_select;
  assign fi.wait_en   = st.wait_enable;
  assign fi.start     = st.start;
  assign fi.load      = st.load;
  assign fi.load_code = st.load_code;
  assign fi.tx        = st.tx;
  // edges seen on the second and third flop only
  assign fi.xrise     = st.xs[1] & ~st.xs[2];
  assign fi.xfall     = ~st.xs[1] & st.xs[2];

  sbmc_frame u_frame (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .fi      (fi)
  );

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign scl_o            = fi.scl_o;
  assign scl_oe_n         = fi.scl_oe_n;
  assign sda_o            = fi.sda_o;
  assign sda_oe_n         = fi.sda_oe_n;
  assign bit_order_select = st.bit_order_select;
  assign wait_enable      = st.wait_enable;

endmodule : sbmc_top

// [core/sbmc_regs.svh]
// register map, field positions, reset values and timing counts
// assumes a 32-bit APB slave at byte addresses, pclk at 125 MHz
// How it works
// - bit order select 0 shifts msb first, 1 lsb first; resets to 0
// - two-wire master with wait holds clock low two transfer clocks before ack
// - wait off: data bits and ack bit run back to back
// - wait setting ignored as slave and in clocked synchronous format
// - the two reserved bits read as 1 and ignore writes
// - write with guard 0 loads the three-bit frame bit count
// - write with guard 1 leaves the frame bit count unchanged
// - guard position always reads as 1
// - two-wire adds ack: 000 is 9 bits, n is n+1; sync: 000 is 8
// - count field reads remaining bits and returns to 000 after the frame
`ifndef SBMC_REGS_SVH
`define SBMC_REGS_SVH

`define SBMC_OFF_MODE        8'h00
`define SBMC_OFF_LINK        8'h04
`define SBMC_OFF_TXDATA      8'h08
`define SBMC_OFF_STATUS      8'h0C

`define SBMC_MODE_ORDER_BIT  7
`define SBMC_MODE_WAIT_BIT   6
`define SBMC_MODE_GUARD_BIT  3
`define SBMC_MODE_RSVD       8'h30
`define SBMC_MODE_GUARD_RD   8'h08
`define SBMC_MODE_RESET      8'h38

`define SBMC_LINK_TWO_WIRE   0
`define SBMC_LINK_MASTER     1
`define SBMC_LINK_START      2
`define SBMC_LINK_RESET      2'h3

`define SBMC_ORDER_RESET     1'b0
`define SBMC_WAIT_RESET      1'b0
`define SBMC_TWO_WIRE_RESET  1'b1
`define SBMC_MASTER_RESET    1'b1

`define SBMC_STAT_BUSY       0
`define SBMC_STAT_SCL        1
`define SBMC_STAT_SDA        2

`define SBMC_BITS_TWO_WIRE0  4'h9
`define SBMC_BITS_SYNC0      4'h8
`define SBMC_STRETCH_CLOCKS  2'h2

`endif

// [core/sbmc_pkg.sv]
// types used only by the frame sequencer inside the mode-control top
// assumes sbmc_regs.svh for all numeric constants
package sbmc_pkg;

  typedef enum logic [1:0] {
    SBMC_IDLE    = 2'b00,
    SBMC_RUN     = 2'b01,
    SBMC_STRETCH = 2'b10
  } sbmc_phase_t;

endpackage : sbmc_pkg

// [core/sbmc_frame_if.sv]
// link between register side and frame sequencer
// assumes both ends on pclk
`timescale 1ns/100ps
interface sbmc_frame_if;
  logic       two_wire;
  logic       master;
  logic       msb_first;
  logic       wait_en;
  logic       start;
  logic       load;
  logic [2:0] load_code;
  logic [7:0] tx;
  logic       xrise;
  logic       xfall;
  logic       busy;
  logic [2:0] field;
  logic       scl_o;
  logic       scl_oe_n;
  logic       sda_o;
  logic       sda_oe_n;

  modport ctl (output two_wire, master, msb_first, wait_en, start, load, load_code, tx,
               xrise, xfall, input busy, field, scl_o, scl_oe_n, sda_o, sda_oe_n);
  modport eng (input two_wire, master, msb_first, wait_en, start, load, load_code, tx,
               xrise, xfall, output busy, field, scl_o, scl_oe_n, sda_o, sda_oe_n);
endinterface : sbmc_frame_if

// [core/sbmc_frame.sv]
// frame sequencer: bit counting, clock stretch, serial data order
// assumes transfer clock edges arrive as one-cycle pulses on pclk
`timescale 1ns/100ps
`include "sbmc_regs.svh"
module sbmc_frame (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   ce,
  sbmc_frame_if.eng   fi
);

  typedef struct packed {
    sbmc_pkg::sbmc_phase_t phase;
    logic [3:0]            rem;
    logic [2:0]            field;
    logic [7:0]            sh;
    logic [1:0]            stretch;
    logic                  scl_o;
    logic                  scl_oe_n;
    logic                  sda_o;
    logic                  sda_oe_n;
  } sbmc_frame_st_t;

  sbmc_frame_st_t st;
  sbmc_frame_st_t next_st;

  // code to total bits in the frame
  function automatic logic [3:0] sbmc_bits(input logic [2:0] code, input logic tw);
    if (code == 3'h0) begin
      sbmc_bits = tw ? `SBMC_BITS_TWO_WIRE0 : `SBMC_BITS_SYNC0;
    end else begin
      sbmc_bits = {1'b0, code} + {3'h0, tw};
    end
  endfunction : sbmc_bits

  // remaining bits back to field code; 9 or 8 wraps to 000
  function automatic logic [2:0] sbmc_code(input logic [3:0] bits, input logic tw);
    logic [3:0] c;
    c = bits - {3'h0, tw};
    sbmc_code = c[2:0];
  endfunction : sbmc_code

  logic data_bit;
  logic ack_phase;
  logic stretch_on;

  always_comb begin
    next_st    = st;
    data_bit   = fi.msb_first ? st.sh[7] : st.sh[0];
    ack_phase  = fi.two_wire && (st.rem == 4'h1);
    // wait only counts for a two-wire master
    stretch_on = fi.wait_en && fi.two_wire && fi.master;
    unique case (st.phase)
      sbmc_pkg::SBMC_IDLE: begin
        if (fi.start) begin
          next_st.phase = sbmc_pkg::SBMC_RUN;
          next_st.rem   = sbmc_bits(st.field, fi.two_wire);
          next_st.sh    = fi.tx;
        end
      end
      sbmc_pkg::SBMC_RUN: begin
        if (fi.xfall) begin
          next_st.rem   = st.rem - 4'h1;
          next_st.sh    = fi.msb_first ? {st.sh[6:0], 1'b0} : {1'b0, st.sh[7:1]};
          next_st.field = sbmc_code(st.rem - 4'h1, fi.two_wire);
          if (st.rem == 4'h1) begin
            next_st.phase = sbmc_pkg::SBMC_IDLE;
            next_st.field = 3'h0;
          end else if (st.rem == 4'h2 && stretch_on) begin
            next_st.phase   = sbmc_pkg::SBMC_STRETCH;
            next_st.stretch = 2'h0;
          end
          // without wait the ack bit follows at once
        end
      end
      sbmc_pkg::SBMC_STRETCH: begin
        if (fi.xrise) begin
          next_st.stretch = st.stretch + 2'h1;
          if (st.stretch + 2'h1 == `SBMC_STRETCH_CLOCKS) begin
            next_st.phase = sbmc_pkg::SBMC_RUN;
          end
        end
      end
      default: begin
        next_st.phase = sbmc_pkg::SBMC_IDLE;
      end
    endcase
    // a load while running restarts the count from the new code
    if (fi.load) begin
      next_st.field = fi.load_code;
      if (st.phase != sbmc_pkg::SBMC_IDLE) begin
        next_st.rem = sbmc_bits(fi.load_code, fi.two_wire);
      end
    end
    // clock pin: master follows the transfer clock, stretch holds it low
    next_st.scl_o    = 1'b0;
    next_st.scl_oe_n = 1'b1;
    if (fi.master && next_st.phase == sbmc_pkg::SBMC_STRETCH) begin
      next_st.scl_oe_n = 1'b0;
    end else if (fi.master && next_st.phase == sbmc_pkg::SBMC_RUN) begin
      if (fi.xfall) begin
        next_st.scl_oe_n = 1'b0;
      end else if (fi.xrise) begin
        next_st.scl_oe_n = 1'b1;
      end else begin
        next_st.scl_oe_n = st.scl_oe_n;
      end
    end
    // data pin: open drain in two-wire, ack left to the receiver
    next_st.sda_o    = 1'b0;
    next_st.sda_oe_n = 1'b1;
    if (st.phase != sbmc_pkg::SBMC_IDLE) begin
      if (fi.two_wire) begin
        next_st.sda_oe_n = ack_phase | data_bit;
      end else begin
        next_st.sda_o    = data_bit;
        next_st.sda_oe_n = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: sbmc_pkg::SBMC_IDLE, rem: 4'h0, field: 3'h0, sh: 8'h00,
              stretch: 2'h0, scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign fi.busy     = (st.phase != sbmc_pkg::SBMC_IDLE);
  assign fi.field    = st.field;
  assign fi.scl_o    = st.scl_o;
  assign fi.scl_oe_n = st.scl_oe_n;
  assign fi.sda_o    = st.sda_o;
  assign fi.sda_oe_n = st.sda_oe_n;

endmodule : sbmc_frame

// [sim/sbmc_monitor.sv]
// checker: apb mode register relations and scl drive
// assumes bind into sbmc_top, one pclk domain
`timescale 1ns/100ps
module sbmc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        bit_order_select,
  input wire logic        wait_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mwr;
  logic mrd;
  assign acc = psel && penable && pready;
  assign mwr = acc && pwrite && paddr == 8'h00;
  assign mrd = acc && !pwrite && paddr == 8'h00;
  AST_ORDER_WR: assert property (mwr |=> bit_order_select == $past(pwdata[7]))
    else $error("bit order select missed its write");
  AST_ORDER_HOLD: assert property (!mwr |=> $stable(bit_order_select))
    else $error("bit order select moved without a write");
  AST_WAIT_WR: assert property (mwr |=> wait_enable == $past(pwdata[6]))
    else $error("wait enable missed its write");
  AST_WAIT_HOLD: assert property (!mwr |=> $stable(wait_enable))
    else $error("wait enable moved without a write");
  AST_RSVD_RD: assert property (mrd |-> prdata[5:4] == 2'b11 && prdata[31:8] == 24'h00_0000)
    else $error("reserved bits read wrong");
  AST_GUARD_RD: assert property (mrd |-> prdata[3])
    else $error("guard bit read as 0");
  AST_ANSWER: assert property (psel && penable && !pready && ce |=> pready)
    else $error("access not answered after one wait state");
  AST_UNMAPPED: assert property (acc && paddr > 8'h0C |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_SCL_LOW: assert property (!scl_oe_n |-> !scl_o)
    else $error("scl driven high");
  cover property (mwr);
  cover property (mrd);
  cover property (!scl_oe_n);
  cover property (acc && pslverr);
endmodule : sbmc_monitor

bind sbmc_top sbmc_monitor sbmc_monitor_i (.*);

// [sim/sbmc_peer.sv]
// far-side peer: transfer clock during frames, pull-ups on both wires
// assumes the bench raises run for one frame at a time
`timescale 1ns/100ps
module sbmc_peer (
  input  wire logic run,
  input  wire logic scl_o,
  input  wire logic scl_oe_n,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  output logic      xfer_clk,
  output logic      scl_i,
  output logic      sda_i
);
  // released wires float high, peer never acks
  assign scl_i = scl_oe_n | scl_o;
  assign sda_i = sda_oe_n | sda_o;
  // clock stands low between frames; each bit is sampled on a rise, ended by a fall
  initial begin
    xfer_clk = 1'b0;
    forever begin
      wait (run);
      #62.5 xfer_clk = 1'b1;
      #62.5 xfer_clk = 1'b0;
    end
  end
endmodule : sbmc_peer

// [sim/serial_bus_mode_control_bench.sv]
// self-checking bench: apb master, queue of expected reads, frames on the peer
// assumes sbmc_top with the peer model on its pins
`timescale 1ns/100ps
module serial_bus_mode_control_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv, seed;
  logic        pready, pslverr, xfer_clk, scl_i, scl_o, scl_oe_n, sda_i, sda_o, sda_oe_n;
  logic        bit_order_select, wait_enable;
  logic        run = 1'b0;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [7:0]  pat;
  logic [2:0]  cnt = 3'h5;
  int          n_errors = 0, checks_done = 0, falls, stretch, rises;
  always #4 pclk = ~pclk;
  sbmc_top sbmc_top_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .xfer_clk, .scl_i, .scl_o, .scl_oe_n, .sda_i,
    .sda_o, .sda_oe_n, .bit_order_select, .wait_enable);
  sbmc_peer sbmc_peer_i (.run, .scl_o, .scl_oe_n, .sda_o, .sda_oe_n, .xfer_clk, .scl_i,
    .sda_i);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    notes.push_back({1'b1, exp});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // status polls carry a don't-care note
  task automatic frame(input logic [7:0] mode, input logic [7:0] link);
    wr(8'h00, mode);
    wr(8'h08, 32'h0000_00C1);
    falls = 0;
    stretch = 0;
    rises = 0;
    wr(8'h04, link);
    // write answer carries link bits, not busy: force the first poll
    rv = 32'h0000_0001;
    run <= 1'b1;
    for (int i = 0; i < 3000 && rv[0] !== 1'b0; i++) begin
      notes.push_back(34'h0_0000_0000);
      apb(1'b0, 8'h0C, 32'h0000_0000);
    end
    run <= 1'b0;
    #300;
    chk("busy", 0, rv[0]);
  endtask : frame
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      if (nt[33]) chk("read", nt[32:0], {pslverr, prdata});
    end
  end
  // the peer may finish one idle clock after the frame; only count while running
  always @(negedge xfer_clk) begin
    if (run) begin
      falls++;
    end
  end
  // sampled late in the high phase, after any release has landed
  always @(posedge xfer_clk) begin
    #52;
    stretch += (scl_i === 1'b0);
    if (rises < 8) pat = {pat[6:0], sda_i};
    rises++;
  end
  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    seed = 32'h0000_7582;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h0_0000_0038);
    wr(8'h00, 32'h0000_00C5);
    rd(8'h00, 33'h0_0000_00FD);
    wr(8'h00, 32'h0000_003E);
    rd(8'h00, 33'h0_0000_003D);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      cnt = seed[3] ? cnt : seed[2:0];
      wr(8'h00, seed);
      rd(8'h00, {25'h000_0000, seed[7:6], 3'b111, cnt});
    end
    rd(8'h10, 33'h1_0000_0000);
    frame(8'h00, 8'h07);
    chk("falls", 9, falls);
    chk("stretch", 0, stretch);
    chk("pattern", 8'hC1, pat);
    frame(8'h40, 8'h07);
    chk("stretch", 1, stretch);
    frame(8'h40, 8'h05);
    chk("stretch", 0, stretch);
    frame(8'hC8, 8'h06);
    chk("falls", 8, falls);
    chk("stretch", 0, stretch);
    chk("pattern", 8'h83, pat);
    frame(8'h02, 8'h07);
    chk("falls", 3, falls);
    rd(8'h00, 33'h0_0000_0038);
    complete_run;
  end
endmodule : serial_bus_mode_control_bench
